// >>> tb.sv
// Self-checking testbench for the descriptor source.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_reset = 1'b1, i_start = 1'b0, slow = 1'b0;
    logic i_ready, o_valid, o_last, o_busy;
    logic [7:0] o_data;
    wa_desc_pkg::desc_sel_type i_sel = wa_desc_pkg::DESC_CLASS;
    int failures = 0;
    int num_checks = 0;
    wire_adapter_descriptor_rom #(.MAX_DEVICES(8'h05), .PIPE_COUNT(16'h1234), .BLOCK_TOTAL(16'hA5C3),
        .BLOCK_EXP(8'h0A), .IE_BLOCKS(8'hFF)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start),
        .i_sel(i_sel), .i_ready(i_ready), .o_valid(o_valid), .o_data(o_data), .o_last(o_last), .o_busy(o_busy));
    wa_host_model host_u (.i_clk(i_clk), .i_valid(o_valid), .i_data(o_data), .i_last(o_last),
        .i_slow(slow), .o_ready(i_ready));
    initial forever #5 i_clk = ~i_clk;
    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task end_sim;
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // Requests one descriptor, optionally issues a second start for the read descriptor mid-transfer, and compares the stream.
    task run(input wa_desc_pkg::desc_sel_type sel, input logic stall, input logic bump, input logic [7:0] exp[$]);
        int k;
        host_u.got.delete();
        host_u.lasts.delete();
        slow = stall;
        i_sel = sel;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        if (bump) begin
            repeat (3) @(negedge i_clk);
            i_sel = wa_desc_pkg::DESC_READ;
            i_start = 1'b1;
            @(negedge i_clk);
            i_start = 1'b0;
        end
        k = 0;
        while (!(host_u.got.size() == exp.size() && !o_busy) && k < 300) begin
            @(negedge i_clk);
            k++;
        end
        check(8'(host_u.got.size()), 8'(exp.size()), "byte count");
        foreach (exp[i]) begin
            check((i < host_u.got.size()) ? host_u.got[i] : 8'hXX, exp[i], "descriptor byte");
            check({7'h00, (i < host_u.lasts.size()) ? host_u.lasts[i] : 1'bx},
                {7'h00, i == exp.size() - 1}, "final flag");
        end
        repeat (4) @(negedge i_clk);
        check({7'h00, o_busy}, 8'h00, "busy after end");
    endtask : run
    task test_class;
        run(wa_desc_pkg::DESC_CLASS, 1'b0, 1'b0, '{8'h0E, 8'h21, 8'h00, 8'h01, 8'h05, 8'h00, 8'h34, 8'h12,
            8'hC3, 8'hA5, 8'h0A, 8'h00, 8'hFF, 8'h00});
        $display("Class descriptor test done.");
    endtask : test_class
    task test_notify_slow;
        run(wa_desc_pkg::DESC_NOTIFY, 1'b1, 1'b0, '{8'h07, 8'h05, 8'h81, 8'h03, 8'h40, 8'h00, 8'h01});
        $display("Notification endpoint test done.");
    endtask : test_notify_slow
    task test_bulk_pair;
        run(wa_desc_pkg::DESC_WRITE, 1'b0, 1'b0, '{8'h07, 8'h05, 8'h02, 8'h02, 8'h00, 8'h02, 8'h00});
        run(wa_desc_pkg::DESC_READ, 1'b1, 1'b0, '{8'h07, 8'h05, 8'h83, 8'h02, 8'h00, 8'h02, 8'h00});
        $display("Bulk endpoint test done.");
    endtask : test_bulk_pair
    task test_refused_restart;
        run(wa_desc_pkg::DESC_NOTIFY, 1'b1, 1'b1, '{8'h07, 8'h05, 8'h81, 8'h03, 8'h40, 8'h00, 8'h01});
        $display("Ignored restart test done.");
    endtask : test_refused_restart
    task test_mid_reset;
        i_sel = wa_desc_pkg::DESC_CLASS;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        repeat (4) @(negedge i_clk);
        i_reset = 1'b1;
        repeat (2) @(negedge i_clk);
        check({o_valid, o_last, o_busy, 5'h00}, 8'h00, "flags in reset");
        check(o_data, 8'h00, "data in reset");
        i_reset = 1'b0;
        test_class();
        $display("Reset during transfer test done.");
    endtask : test_mid_reset
    initial begin
        repeat (12) @(negedge i_clk);
        i_reset = 1'b0;
        test_class();
        test_notify_slow();
        test_bulk_pair();
        test_refused_restart();
        test_mid_reset();
        end_sim();
    end
    initial begin
        #100us;
        failures++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule : tb
`default_nettype wire

// >>> wa_desc_byte.sv
// Combinational lookup of one descriptor byte by selector and offset.
`default_nettype none
`include "wa_desc_defs.svh"
module wa_desc_byte #(
    parameter logic [7:0]  MAX_DEVICES  = 8'h01,
    parameter logic [15:0] PIPE_COUNT   = 16'h0001,
    parameter logic [15:0] BLOCK_TOTAL  = 16'h0001,
    parameter logic [7:0]  BLOCK_EXP    = 8'h0A,
    parameter logic [7:0]  IE_BLOCKS    = 8'h01,
    parameter logic [7:0]  NOTIFY_ADDR  = 8'h81,
    parameter logic [7:0]  WRITE_ADDR   = 8'h02,
    parameter logic [7:0]  READ_ADDR    = 8'h83,
    parameter logic [15:0] BULK_MPS     = 16'h0200
) (
    input  wire wa_desc_pkg::desc_sel_type i_sel,
    input  wire logic [3:0]                i_offset,
    output logic [7:0]                     o_byte,
    output logic [3:0]                     o_last
);
    always_comb begin
        o_byte = 8'h00;
        o_last = 4'(`EP_LEN - 8'h01);
        unique case (i_sel)
            wa_desc_pkg::DESC_CLASS: begin
                o_last = 4'(`CLS_LEN - 8'h01);
                unique case (i_offset)
                    `OFS_LEN:         o_byte = `CLS_LEN;                     // [R01]
                    `OFS_TYPE:        o_byte = `CLS_TYPE;                    // [R01]
                    `OFS_RELEASE_LO:  o_byte = `CLS_RELEASE_LO;              // [R02] [R19]
                    `OFS_RELEASE_HI:  o_byte = `CLS_RELEASE_HI;              // [R02]
                    `OFS_PORTS:       o_byte = MAX_DEVICES;                  // [R03]
                    `OFS_ATTR:        o_byte = `CLS_ATTR;                    // [R04]
                    `OFS_PIPES_LO:    o_byte = PIPE_COUNT[7:0];              // [R05] [R19]
                    `OFS_PIPES_HI:    o_byte = PIPE_COUNT[15:8];             // [R05]
                    `OFS_BLOCKS_LO:   o_byte = BLOCK_TOTAL[7:0];             // [R06] [R19]
                    `OFS_BLOCKS_HI:   o_byte = BLOCK_TOTAL[15:8];            // [R06]
                    `OFS_BLOCK_SIZE:  o_byte = BLOCK_EXP;                    // [R07]
                    `OFS_PWR_GOOD:    o_byte = `CLS_PWR_GOOD;                // [R08]
                    `OFS_IE_COUNT:    o_byte = IE_BLOCKS;                    // [R09]
                    `OFS_REMOVABLE:   o_byte = `CLS_REMOVABLE;               // [R11]
                    default:          o_byte = 8'h00;
                endcase
            end
            default: begin
                unique case (i_offset)
                    `OFS_LEN:         o_byte = `EP_LEN;                      // [R18]
                    `OFS_TYPE:        o_byte = `EP_TYPE;                     // [R18]
                    `OFS_EP_ADDR:     o_byte = (i_sel == wa_desc_pkg::DESC_NOTIFY) ? NOTIFY_ADDR :
                                               (i_sel == wa_desc_pkg::DESC_WRITE) ? WRITE_ADDR : READ_ADDR;
                    `OFS_EP_ATTR:     o_byte = (i_sel == wa_desc_pkg::DESC_NOTIFY) ?
                                               `EP_ATTR_INTR : `EP_ATTR_BULK; // [R12] [R16] [R17]
                    `OFS_EP_MPS_LO:   o_byte = (i_sel == wa_desc_pkg::DESC_NOTIFY) ?
                                               `EP_NOTIFY_MPS_LO : BULK_MPS[7:0]; // [R13] [R19]
                    `OFS_EP_MPS_HI:   o_byte = (i_sel == wa_desc_pkg::DESC_NOTIFY) ?
                                               `EP_NOTIFY_MPS_HI : BULK_MPS[15:8]; // [R13]
                    `OFS_EP_INTERVAL: o_byte = (i_sel == wa_desc_pkg::DESC_NOTIFY) ?
                                               `EP_NOTIFY_INTERVAL : `EP_BULK_INTERVAL; // [R14] [R16] [R17]
                    default:          o_byte = 8'h00;
                endcase
            end
        endcase
    end
endmodule : wa_desc_byte
`default_nettype wire

// >>> wa_desc_defs.svh
// Constants for the wire adapter descriptor source.
`ifndef WA_DESC_DEFS_SVH
`define WA_DESC_DEFS_SVH
`define CLS_LEN            8'h0E
`define CLS_TYPE           8'h21
`define CLS_RELEASE_LO     8'h00
`define CLS_RELEASE_HI     8'h01
`define CLS_ATTR           8'h00
`define CLS_PWR_GOOD       8'h00
`define CLS_REMOVABLE      8'h00
`define EP_LEN             8'h07
`define EP_TYPE            8'h05
`define EP_ATTR_INTR       8'h03
`define EP_ATTR_BULK       8'h02
`define EP_NOTIFY_MPS_LO   8'h40
`define EP_NOTIFY_MPS_HI   8'h00
`define EP_NOTIFY_INTERVAL 8'h01
`define EP_BULK_INTERVAL   8'h00
`define OFS_LEN            4'h0
`define OFS_TYPE           4'h1
`define OFS_RELEASE_LO     4'h2
`define OFS_RELEASE_HI     4'h3
`define OFS_PORTS          4'h4
`define OFS_ATTR           4'h5
`define OFS_PIPES_LO       4'h6
`define OFS_PIPES_HI       4'h7
`define OFS_BLOCKS_LO      4'h8
`define OFS_BLOCKS_HI      4'h9
`define OFS_BLOCK_SIZE     4'hA
`define OFS_PWR_GOOD       4'hB
`define OFS_IE_COUNT       4'hC
`define OFS_REMOVABLE      4'hD
`define OFS_EP_ADDR        4'h2
`define OFS_EP_ATTR        4'h3
`define OFS_EP_MPS_LO      4'h4
`define OFS_EP_MPS_HI      4'h5
`define OFS_EP_INTERVAL    4'h6
`define IE_BLOCK_BYTES     255
`endif

// >>> wa_desc_pkg.sv
// Types shared by the wire adapter descriptor source.
`default_nettype none
package wa_desc_pkg;
    typedef enum logic [1:0] {
        DESC_CLASS,
        DESC_NOTIFY,
        DESC_WRITE,
        DESC_READ
    } desc_sel_type;
endpackage : wa_desc_pkg
`default_nettype wire

// >>> wa_host_model.sv
// Host side reader that accepts descriptor bytes, promptly or with stalls.
`default_nettype none
module wa_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_valid,
    input  wire logic [7:0] i_data,
    input  wire logic       i_last,
    input  wire logic       i_slow,
    output logic            o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic       lasts[$];
    int         tick = 0;
    initial o_ready = 1'b0;
    // In slow mode the reader accepts only one cycle in three.
    always @(negedge i_clk) begin
        tick <= tick + 1;
        o_ready <= !i_slow || (tick % 3 == 0);
    end
    // Every byte taken at a rising edge is kept with its final-byte flag.
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            got.push_back(i_data);
            lasts.push_back(i_last);
        end
    end
endmodule : wa_host_model
`default_nettype wire

// >>> wire_adapter_descriptor_rom.sv
// Streams the adapter class and endpoint descriptors one byte per handshake.
`default_nettype none
`include "wa_desc_defs.svh"
// Functional notes
// R01: Class descriptor byte 1 is type 21H; byte 0 is its total length.
// R02: Offsets 2 and 3 hold class release 0100H in BCD.
// R03: Offset 4 gives maximum number of concurrently connected devices.
// R04: Offset 5 attribute bitmap is reserved and always zero.
// R05: Offsets 6 and 7 give the remote pipe count.
// R06: Offsets 8 and 9 give total buffer blocks shared by all pipes.
// R07: Offset 10 gives block size exponent; block holds two to n minus one bytes.
// R08: Offset 11 power good delay is zero for a host side adapter.
// R09: Offset 12 gives info element block count, legal from 1 to FFH.
// R10: Each advertised info element block has at least 255 bytes of storage.
// R11: Offset 13 removable bitmap is one byte, all zero.
// R12: Notification endpoint attribute byte is 00000011b, interrupt.
// R13: Notification endpoint maximum packet size is 40H.
// R14: Notification endpoint polling interval is 1 frame or microframe.
// R15: Notification endpoint carries device notifications, status and completions.
// R16: Write endpoint is bulk, attribute 00000010b, interval 0.
// R17: Read endpoint is bulk, attribute 00000010b, interval 0.
// R18: Each endpoint descriptor is 7 bytes with type code 5.
// R19: Multi-byte fields go low byte first; bytes stream in ascending offset.
module wire_adapter_descriptor_rom #(
    parameter logic [7:0]  MAX_DEVICES    = 8'h01,
    parameter logic [15:0] PIPE_COUNT     = 16'h0001,
    parameter logic [15:0] BLOCK_TOTAL    = 16'h0001,
    parameter logic [7:0]  BLOCK_EXP      = 8'h0A,
    parameter logic [7:0]  IE_BLOCKS      = 8'h01,
    parameter int          IE_BLOCK_STORE = 255,
    parameter logic [7:0]  NOTIFY_ADDR    = 8'h81,
    parameter logic [7:0]  WRITE_ADDR     = 8'h02,
    parameter logic [7:0]  READ_ADDR      = 8'h83,
    parameter logic [15:0] BULK_MPS       = 16'h0200
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_reset,
    input  wire logic                      i_start,
    input  wire wa_desc_pkg::desc_sel_type i_sel,
    input  wire logic                      i_ready,
    output logic                           o_valid,
    output logic [7:0]                     o_data,
    output logic                           o_last,
    output logic                           o_busy
);
    // Parameter values that the descriptor may not advertise stop elaboration.
    if (IE_BLOCKS == 8'h00) begin : g_bad_ie_count
        $error("Info element block count must be 1 to FFH."); // [R09]
    end
    if (IE_BLOCK_STORE < `IE_BLOCK_BYTES) begin : g_bad_ie_store
        $error("Info element block storage below 255 bytes."); // [R10]
    end

    typedef enum logic [0:0] {
        IDLE,
        SEND
    } state_type;

    state_type                 state;
    wa_desc_pkg::desc_sel_type sel;
    logic [3:0]                offset;
    logic [7:0]                next_byte;
    logic [3:0]                last_offset;
    logic                      take;
    logic                      load;
    logic                      begin_req;

    wa_desc_byte #(
        .MAX_DEVICES (MAX_DEVICES),
        .PIPE_COUNT  (PIPE_COUNT),
        .BLOCK_TOTAL (BLOCK_TOTAL),
        .BLOCK_EXP   (BLOCK_EXP),
        .IE_BLOCKS   (IE_BLOCKS),
        .NOTIFY_ADDR (NOTIFY_ADDR),
        .WRITE_ADDR  (WRITE_ADDR),
        .READ_ADDR   (READ_ADDR),
        .BULK_MPS    (BULK_MPS)
    ) u_byte (
        .i_sel    (sel),
        .i_offset (offset),
        .o_byte   (next_byte),
        .o_last   (last_offset)
    );

    assign take   = o_valid && i_ready;
    assign o_busy = (state == SEND);
    assign begin_req = (state == IDLE) && i_start;
    assign load      = (state == SEND) && !o_valid;

    // Control state: a start is taken only while idle; the final take returns to idle.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= IDLE;
        end else begin
            unique case (state)
                IDLE: begin
                    if (i_start) begin
                        state <= SEND;
                    end
                end
                SEND: begin
                    if (take && o_last) begin
                        state <= IDLE;
                    end
                end
            endcase
        end
    end

    // The selector is latched with the start and held for the whole descriptor.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sel <= wa_desc_pkg::DESC_CLASS;
        end else if (begin_req) begin
            sel <= i_sel;
        end
    end

    // The offset restarts on each start taken while idle and steps by one for each byte taken except the final one.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            offset <= `OFS_LEN;
        end else if (begin_req) begin
            offset <= `OFS_LEN;
        end else if (take && !o_last) begin
            offset <= offset + 4'h1; // [R19]
        end
    end

    // A byte is offered one cycle after its offset settles and withdrawn once taken.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_valid <= 1'b0;
        end else if (load) begin
            o_valid <= 1'b1;
        end else if (take) begin
            o_valid <= 1'b0;
        end
    end

    // The byte under the current offset is held in o_data while o_valid stands.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_data <= 8'h00;
        end else if (load) begin
            o_data <= next_byte;
        end
    end

    // The final flag is loaded with its byte and held until that byte is taken.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_last <= 1'b0;
        end else if (load) begin
            o_last <= (offset == last_offset);
        end
    end

    // Notifications, status and completions are produced elsewhere; this block
    // only advertises the interrupt endpoint that carries them. [R15]

    AST_CLASS_TYPE: assert property (@(posedge i_clk) disable iff (i_reset) // [R01]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_TYPE |-> o_data == 8'h21)
        else $error("Class descriptor type byte wrong.");

    AST_CLASS_LEN: assert property (@(posedge i_clk) disable iff (i_reset) // [R01]
        take && o_last && sel == wa_desc_pkg::DESC_CLASS |-> offset == 4'(`CLS_LEN - 8'h01))
        else $error("Class descriptor length mismatch.");

    AST_CLASS_LEN_BYTE: assert property (@(posedge i_clk) disable iff (i_reset) // [R01]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_LEN |-> o_data == 8'h0E)
        else $error("Class descriptor length byte wrong.");

    AST_RELEASE: assert property (@(posedge i_clk) disable iff (i_reset) // [R02]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_RELEASE_LO
        |-> o_data == 8'h00 ##1 (!take)[*1] ##1 (o_data == 8'h01))
        else $error("Release number bytes wrong.");

    AST_PORTS: assert property (@(posedge i_clk) disable iff (i_reset) // [R03]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_PORTS |-> o_data == MAX_DEVICES)
        else $error("Device count byte wrong.");

    AST_ATTR_ZERO: assert property (@(posedge i_clk) disable iff (i_reset) // [R04] [R08] [R11]
        take && sel == wa_desc_pkg::DESC_CLASS && (offset == `OFS_ATTR || offset == `OFS_PWR_GOOD
        || offset == `OFS_REMOVABLE) |-> o_data == 8'h00)
        else $error("Reserved class byte not zero.");

    AST_PIPES: assert property (@(posedge i_clk) disable iff (i_reset) // [R05] [R19]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_PIPES_LO
        |-> o_data == PIPE_COUNT[7:0] ##2 o_data == PIPE_COUNT[15:8])
        else $error("Remote pipe count bytes wrong.");

    AST_BLOCKS: assert property (@(posedge i_clk) disable iff (i_reset) // [R06] [R19]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_BLOCKS_LO
        |-> o_data == BLOCK_TOTAL[7:0] ##2 o_data == BLOCK_TOTAL[15:8])
        else $error("Buffer block total bytes wrong.");

    AST_BLOCK_EXP: assert property (@(posedge i_clk) disable iff (i_reset) // [R07]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_BLOCK_SIZE |-> o_data == BLOCK_EXP)
        else $error("Block size exponent wrong.");

    AST_IE_NONZERO: assert property (@(posedge i_clk) disable iff (i_reset) // [R09]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_IE_COUNT |-> o_data != 8'h00)
        else $error("Info element count is zero.");

    AST_REMOVABLE_LAST: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
        take && sel == wa_desc_pkg::DESC_CLASS && offset == `OFS_REMOVABLE |-> o_last)
        else $error("Removable bitmap is not the single final byte.");

    AST_EP_LEN: assert property (@(posedge i_clk) disable iff (i_reset) // [R18]
        take && o_last && sel != wa_desc_pkg::DESC_CLASS |-> offset == 4'(`EP_LEN - 8'h01))
        else $error("Endpoint descriptor length wrong.");

    AST_EP_LEN_BYTE: assert property (@(posedge i_clk) disable iff (i_reset) // [R18]
        take && sel != wa_desc_pkg::DESC_CLASS && offset == `OFS_LEN |-> o_data == 8'h07)
        else $error("Endpoint length byte wrong.");

    AST_EP_TYPE: assert property (@(posedge i_clk) disable iff (i_reset) // [R18]
        take && sel != wa_desc_pkg::DESC_CLASS && offset == `OFS_TYPE |-> o_data == 8'h05)
        else $error("Endpoint type byte wrong.");

    AST_EP_ATTR: assert property (@(posedge i_clk) disable iff (i_reset) // [R12]
        take && offset == `OFS_EP_ATTR && sel == wa_desc_pkg::DESC_NOTIFY |-> o_data == 8'h03)
        else $error("Endpoint attribute byte wrong.");

    AST_BULK_ATTR: assert property (@(posedge i_clk) disable iff (i_reset) // [R16] [R17]
        take && offset == `OFS_EP_ATTR && (sel == wa_desc_pkg::DESC_WRITE || sel == wa_desc_pkg::DESC_READ)
        |-> o_data == 8'h02)
        else $error("Bulk attribute byte wrong.");

    AST_NOTIFY_MPS: assert property (@(posedge i_clk) disable iff (i_reset) // [R13]
        take && sel == wa_desc_pkg::DESC_NOTIFY && offset == `OFS_EP_MPS_LO |-> o_data == 8'h40)
        else $error("Notification packet size wrong.");

    AST_NOTIFY_MPS_HI: assert property (@(posedge i_clk) disable iff (i_reset) // [R13]
        take && sel == wa_desc_pkg::DESC_NOTIFY && offset == `OFS_EP_MPS_HI |-> o_data == 8'h00)
        else $error("Notification packet size high byte wrong.");

    AST_INTERVAL: assert property (@(posedge i_clk) disable iff (i_reset) // [R14] [R16] [R17]
        take && offset == `OFS_EP_INTERVAL && sel != wa_desc_pkg::DESC_CLASS
        |-> o_data == ((sel == wa_desc_pkg::DESC_NOTIFY) ? 8'h01 : 8'h00))
        else $error("Endpoint interval wrong.");

    AST_ASCEND: assert property (@(posedge i_clk) disable iff (i_reset) // [R19]
        take && !o_last |=> offset == $past(offset) + 4'h1)
        else $error("Offset did not advance by one.");

    AST_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
        o_valid && !i_ready |=> o_valid && $stable(o_data))
        else $error("Byte dropped under back pressure.");

    AST_HOLD_LAST: assert property (@(posedge i_clk) disable iff (i_reset)
        o_valid && !i_ready |=> $stable(o_last))
        else $error("Final flag changed under back pressure.");

    AST_START_OFFER: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_busy && i_start |=> o_busy && !o_valid ##1 o_valid && offset == `OFS_LEN)
        else $error("First byte not offered two cycles after start.");

    AST_GAP: assert property (@(posedge i_clk) disable iff (i_reset)
        take |=> !o_valid)
        else $error("Valid did not drop after a take.");

    AST_IDLE_QUIET: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_busy |-> !o_valid)
        else $error("Byte offered while idle.");

    AST_END_IDLE: assert property (@(posedge i_clk) disable iff (i_reset)
        take && o_last |=> !o_busy)
        else $error("Busy did not fall after the final byte.");

    AST_REFUSED: assert property (@(posedge i_clk) disable iff (i_reset)
        o_busy |=> $stable(sel))
        else $error("Selector changed during a transfer.");

    COV_CLASS: cover property (@(posedge i_clk) take && o_last && sel == wa_desc_pkg::DESC_CLASS);
    COV_NOTIFY: cover property (@(posedge i_clk) take && o_last && sel == wa_desc_pkg::DESC_NOTIFY);
    COV_WRITE: cover property (@(posedge i_clk) take && o_last && sel == wa_desc_pkg::DESC_WRITE);
    COV_READ: cover property (@(posedge i_clk) take && o_last && sel == wa_desc_pkg::DESC_READ);
    COV_STALL: cover property (@(posedge i_clk) o_valid && !i_ready ##1 take);
endmodule : wire_adapter_descriptor_rom
`default_nettype wire
